/* File: common/osx_pkg.sv */
// Constants, tables and state type of the octal serdes mode and tx port
package osx_pkg;
  localparam int OSX_NCH = 8;
  localparam int OSX_BIT_RATIO = 10;
  localparam logic [3:0] OSX_SYM_LAST = 4'(OSX_BIT_RATIO - 1);
  // Register byte offsets
  localparam logic [7:0] OSX_CTRL_OFS = 8'h00;
  localparam logic [7:0] OSX_SRST_OFS = 8'h04;
  localparam logic [7:0] OSX_STAT_OFS = 8'h08;
  // Control field positions
  localparam int OSX_C_CODE = 0;
  localparam int OSX_C_ERRF = 1;
  localparam int OSX_C_OVR = 2;
  localparam int OSX_C_PA = 3;
  localparam int OSX_C_PB = 4;
  localparam int OSX_C_TCLK = 5;
  localparam int OSX_C_RATE = 6;
  localparam logic OSX_RATE_RST = 1'h1;
  // Status field positions
  localparam int OSX_S_CODE = 0;
  localparam int OSX_S_MUX = 1;
  localparam int OSX_S_NIB = 2;
  localparam int OSX_S_INDEP = 3;
  localparam int OSX_S_RSVD = 4;
  localparam int OSX_S_DISP = 8;
  localparam logic [1:0] OSX_OKAY = 2'h0;
  localparam logic [1:0] OSX_SLVERR = 2'h2;
  // 5b/6b codes abcdei (a at bit 5), negative disparity form
  localparam logic [5:0] OSX_T6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [5:0] OSX_K28_6B = 6'h0F;
  // 3b/4b codes fghj, data and K28 forms
  localparam logic [3:0] OSX_T4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  localparam logic [3:0] OSX_K4 [8] = '{4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'hA, 4'h6, 4'h8};
  localparam logic [3:0] OSX_ALT7 = 4'h7;
  // Whole block state
  typedef struct packed {
    logic awrdy, wrdy, bvalid, arrdy, rvalid, aw_got, w_got;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, wdata;
    logic [7:0] aw_addr;
    logic [3:0] wstrb;
    logic code_en, errf_en, ovr, prog_a, prog_b, tclk_mode, rate_comp;
    logic [7:0] sw_rst;
    logic [3:0] pin1, pin2, tclk1, tclk2, tclk3;
    logic [39:0] lane1, lane2;
    logic [7:0][4:0] stage;
    logic [7:0][9:0] word, shift, rx_word;
    logic [7:0] tx_disp, rx_disp;
    logic [3:0] sym_cnt;
    logic rx_clk;
    logic [39:0] rx_lane;
  } osx_state_t;
  localparam osx_state_t OSX_RST = '{awrdy: 1'h1, wrdy: 1'h1, arrdy: 1'h1,
    rate_comp: OSX_RATE_RST, default: '0};
endpackage : osx_pkg

/* File: rtl/osx_port.sv */
// Mode control, transmit port, 8b/10b coding and serializer of eight lanes
// Overview of operation
// - Coding on if select pin or bit
// - Raw mode takes 10-bit words, LSB first
// - Raw mode outputs 10-bit words both edges
// - Encoded mode samples, realigns, then encodes
// - K-control bit sends control character
// - Multiplexed mode K-control from lane bit 8
// - Bit 8 flags received control character
// - Flag enable high: errors set bits 8..0
// - Flag enable low: violations set bits 7..0
// - Select pins pick multiplexed or nibble bus
// - Override replaces select pins with register
// - Independent clocking if pin or bit high
// - Synchronous mode latches on pair-AB clock
// - Independent mode: each pair own clock
// - Mux: odd on rising, even on falling
// - Nibble: odd bits 9..5, even 4..0
// - Soft reset corrupts partner channel data
// - Encoder keeps running disparity balanced
// - Twelve valid K; invalid K gives error
// - Bit clock tenfold, LSB shifted first
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module osx_port import osx_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register bus write
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // Register bus read
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // Strap pins
  input wire logic coding_select_pin_i,
  input wire logic interface_select_pin_a_i,
  input wire logic interface_select_pin_b_i,
  input wire logic transmit_clock_select_pin_i,
  // Host transmit side
  input wire logic tx_clock_pair_ab_i,
  input wire logic tx_clock_pair_cd_i,
  input wire logic tx_clock_pair_ef_i,
  input wire logic tx_clock_pair_gh_i,
  input wire logic [39:0] transmit_bus_lane_i,
  // Deserializer symbols, same clock
  input wire logic rx_symbol_valid_i,
  input wire logic [79:0] rx_symbol_i,
  // Outputs
  output logic [7:0] serial_data_o,
  output logic receive_clock_o,
  output logic [39:0] receive_bus_lane_o,
  output logic rate_compensation_o
);

  // Registered state and its next value
  osx_state_t s_r;
  osx_state_t s_nxt;

  // Valid control characters only
  function automatic logic k_ok(input logic [7:0] d);
    k_ok = (d[4:0] == 5'h1C) || (d == 8'hF7) || (d == 8'hFB)
      || (d == 8'hFD) || (d == 8'hFE);
  endfunction : k_ok

  // Encoder: returns {disparity out, code}; code bit 0 leaves first
  function automatic logic [10:0] enc(input logic [7:0] d, input logic k,
                                      input logic rdp);
    logic [5:0] s6;
    logic [3:0] s4;
    logic r6;
    logic ro;
    logic [9:0] str;
    logic [10:0] res;
    s6 = (k && d[4:0] == 5'h1C) ? OSX_K28_6B : OSX_T6[d[4:0]];
    // Positive disparity takes the complement of unbalanced or D7
    if (rdp && ($countones(s6) != 3 || d[4:0] == 5'h07)) begin
      s6 = ~s6;
    end
    r6 = rdp ^ ($countones(s6) != 3);
    if (k && d[4:0] == 5'h1C) begin
      s4 = rdp ? ~OSX_K4[d[7:5]] : OSX_K4[d[7:5]];
    end else if (d[7:5] == 3'h7 && (k
        || (!r6 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14))
        || (r6 && (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E)))) begin
      // Alternate x.7 avoids run length of five
      s4 = r6 ? ~OSX_ALT7 : OSX_ALT7;
    end else begin
      s4 = OSX_T4[d[7:5]];
      if (r6 && ($countones(s4) != 2 || d[7:5] == 3'h3)) begin
        s4 = ~s4;
      end
    end
    ro = r6 ^ ($countones(s4) != 2);
    // Bad K request: illegal tail makes the far end see an error
    if (k && !k_ok(d)) begin
      s4 = r6 ? 4'h0 : 4'hF;
      ro = r6;
    end
    str = {s6, s4};
    for (int b = 0; b < 10; b++) begin
      res[b] = str[9 - b];
    end
    res[10] = ro;
    enc = res;
  endfunction : enc

  // Decoder by search over legal characters: {disp, k, d, viol, disp err}
  // Trades area for a table that cannot disagree with the encoder
  function automatic logic [11:0] dec(input logic [9:0] sym, input logic rdp);
    logic [10:0] ec;
    logic [10:0] eo;
    logic hc;
    logic ho;
    logic [8:0] vc;
    logic [8:0] vo;
    logic rc;
    logic ro;
    hc = 1'h0;
    ho = 1'h0;
    vc = '0;
    vo = '0;
    rc = rdp;
    ro = rdp;
    for (int i = 0; i < 512; i++) begin
      if (i < 256 || k_ok(i[7:0])) begin
        ec = enc(i[7:0], i[8], rdp);
        eo = enc(i[7:0], i[8], !rdp);
        if (!hc && ec[9:0] == sym) begin
          hc = 1'h1;
          vc = i[8:0];
          rc = ec[10];
        end
        if (!ho && eo[9:0] == sym) begin
          ho = 1'h1;
          vo = i[8:0];
          ro = eo[10];
        end
      end
    end
    if (hc) begin
      dec = {rc, vc, 2'h0};
    end else if (ho) begin
      dec = {ro, vo, 2'h1}; // Legal only for the other disparity
    end else begin
      dec = {rdp, 9'h000, 2'h2};
    end
  endfunction : dec

  // Mode decode from synchronised straps and registers
  logic coding_on;
  logic sel_a;
  logic sel_b;
  logic mux_mode;
  logic nib_mode;
  logic indep;
  logic strobe;
  logic cur;
  logic prv;
  logic [9:0] lane;
  logic [10:0] ecode;
  logic [11:0] dres;
  logic [31:0] stat;

  always_comb begin
    coding_on = s_r.pin2[0] | s_r.code_en;
    sel_a = s_r.ovr ? s_r.prog_a : s_r.pin2[1];
    sel_b = s_r.ovr ? s_r.prog_b : s_r.pin2[2];
    mux_mode = !sel_a && !sel_b;
    nib_mode = sel_a && !sel_b;
    indep = s_r.pin2[3] | s_r.tclk_mode;
    strobe = (s_r.sym_cnt == OSX_SYM_LAST);
    stat = '0;
    stat[OSX_S_CODE] = coding_on;
    stat[OSX_S_MUX] = mux_mode;
    stat[OSX_S_NIB] = nib_mode;
    stat[OSX_S_INDEP] = indep;
    stat[OSX_S_RSVD] = !mux_mode && !nib_mode;
    stat[OSX_S_DISP +: 8] = s_r.tx_disp;
  end

  // Next-state logic for bus, capture, serializer and receive
  always_comb begin
    s_nxt = s_r;
    cur = 1'h0;
    prv = 1'h0;
    lane = '0;
    ecode = '0;
    dres = '0;
    // Write address and data taken in either order
    if (s_axi_awvalid_i && s_r.awrdy) begin
      s_nxt.aw_got = 1'h1;
      s_nxt.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_r.wrdy) begin
      s_nxt.w_got = 1'h1;
      s_nxt.wdata = s_axi_wdata_i;
      s_nxt.wstrb = s_axi_wstrb_i;
    end
    if (s_r.bvalid && s_axi_bready_i) begin
      s_nxt.bvalid = 1'h0;
    end
    // Both halves present: perform the write
    if (s_nxt.aw_got && s_nxt.w_got && !s_nxt.bvalid) begin
      s_nxt.aw_got = 1'h0;
      s_nxt.w_got = 1'h0;
      s_nxt.bvalid = 1'h1;
      s_nxt.bresp = OSX_OKAY;
      case (s_nxt.aw_addr & 8'hFC)
        OSX_CTRL_OFS: begin
          if (s_nxt.wstrb[0]) begin
            s_nxt.code_en = s_nxt.wdata[OSX_C_CODE];
            s_nxt.errf_en = s_nxt.wdata[OSX_C_ERRF];
            s_nxt.ovr = s_nxt.wdata[OSX_C_OVR];
            s_nxt.prog_a = s_nxt.wdata[OSX_C_PA];
            s_nxt.prog_b = s_nxt.wdata[OSX_C_PB];
            s_nxt.tclk_mode = s_nxt.wdata[OSX_C_TCLK];
            s_nxt.rate_comp = s_nxt.wdata[OSX_C_RATE];
          end
        end
        OSX_SRST_OFS: begin
          if (s_nxt.wstrb[0]) begin
            s_nxt.sw_rst = s_nxt.wdata[7:0];
          end
        end
        OSX_STAT_OFS: begin
          // Read-only: write ignored
        end
        default: begin
          s_nxt.bresp = OSX_SLVERR;
        end
      endcase
    end
    s_nxt.awrdy = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wrdy = !s_nxt.w_got && !s_nxt.bvalid;
    // Read channel: one outstanding read
    if (s_r.rvalid && s_axi_rready_i) begin
      s_nxt.rvalid = 1'h0;
    end
    if (s_axi_arvalid_i && s_r.arrdy) begin
      s_nxt.rvalid = 1'h1;
      s_nxt.rresp = OSX_OKAY;
      case (s_axi_araddr_i & 8'hFC)
        OSX_CTRL_OFS: begin
          s_nxt.rdata = '0;
          s_nxt.rdata[OSX_C_CODE] = s_r.code_en;
          s_nxt.rdata[OSX_C_ERRF] = s_r.errf_en;
          s_nxt.rdata[OSX_C_OVR] = s_r.ovr;
          s_nxt.rdata[OSX_C_PA] = s_r.prog_a;
          s_nxt.rdata[OSX_C_PB] = s_r.prog_b;
          s_nxt.rdata[OSX_C_TCLK] = s_r.tclk_mode;
          s_nxt.rdata[OSX_C_RATE] = s_r.rate_comp;
        end
        OSX_SRST_OFS: begin
          s_nxt.rdata = {24'h000000, s_r.sw_rst};
        end
        OSX_STAT_OFS: begin
          s_nxt.rdata = stat;
        end
        default: begin
          s_nxt.rdata = '0;
          s_nxt.rresp = OSX_SLVERR;
        end
      endcase
    end
    s_nxt.arrdy = !s_nxt.rvalid;
    // Two-flop synchronisers for pins, clocks and lanes
    s_nxt.pin1 = {transmit_clock_select_pin_i, interface_select_pin_b_i,
                  interface_select_pin_a_i, coding_select_pin_i};
    s_nxt.pin2 = s_r.pin1;
    s_nxt.tclk1 = {tx_clock_pair_gh_i, tx_clock_pair_ef_i,
                   tx_clock_pair_cd_i, tx_clock_pair_ab_i};
    s_nxt.tclk2 = s_r.tclk1;
    s_nxt.tclk3 = s_r.tclk2;
    s_nxt.lane1 = transmit_bus_lane_i;
    s_nxt.lane2 = s_r.lane1;
    // Capture on both edges of each pair's chosen clock
    for (int p = 0; p < 4; p++) begin
      cur = indep ? s_r.tclk2[p] : s_r.tclk2[0];
      prv = indep ? s_r.tclk3[p] : s_r.tclk3[0];
      lane = s_r.lane2[p*10 +: 10];
      if (cur && !prv) begin
        if (mux_mode) begin
          s_nxt.word[2*p+1] = lane;
        end else if (nib_mode) begin
          s_nxt.stage[2*p+1] = lane[9:5];
          s_nxt.stage[2*p] = lane[4:0];
        end
      end
      if (!cur && prv) begin
        if (mux_mode) begin
          s_nxt.word[2*p] = lane;
        end else if (nib_mode) begin
          s_nxt.word[2*p+1] = {lane[9:5], s_r.stage[2*p+1]};
          s_nxt.word[2*p] = {lane[4:0], s_r.stage[2*p]};
        end
      end
      // Shared input bank: either reset clears both lanes of the pair
      if (s_r.sw_rst[2*p] || s_r.sw_rst[2*p+1]) begin
        s_nxt.word[2*p] = '0;
        s_nxt.word[2*p+1] = '0;
        s_nxt.stage[2*p] = '0;
        s_nxt.stage[2*p+1] = '0;
      end
    end
    // Symbol divider: one symbol per ten bit times
    s_nxt.sym_cnt = strobe ? 4'h0 : 4'(s_r.sym_cnt + 4'h1);
    // Serializer load and shift, realigned to the local clock
    for (int c = 0; c < OSX_NCH; c++) begin
      ecode = enc(s_r.word[c][7:0], s_r.word[c][8], s_r.tx_disp[c]);
      if (strobe) begin
        if (coding_on) begin
          s_nxt.shift[c] = ecode[9:0];
          s_nxt.tx_disp[c] = ecode[10];
        end else begin
          s_nxt.shift[c] = s_r.word[c];
        end
      end else begin
        s_nxt.shift[c] = {1'h0, s_r.shift[c][9:1]};
      end
      if (s_r.sw_rst[c]) begin
        s_nxt.tx_disp[c] = 1'h0;
      end
    end
    // Receive decode per symbol
    if (rx_symbol_valid_i) begin
      for (int c = 0; c < OSX_NCH; c++) begin
        dres = dec(rx_symbol_i[c*10 +: 10], s_r.rx_disp[c]);
        if (!coding_on) begin
          s_nxt.rx_word[c] = rx_symbol_i[c*10 +: 10];
        end else begin
          s_nxt.rx_disp[c] = dres[11];
          if (s_r.errf_en && (dres[1] || dres[0])) begin
            s_nxt.rx_word[c] = 10'h1FF;
          end else if (!s_r.errf_en && dres[1]) begin
            s_nxt.rx_word[c] = 10'h0FF;
          end else begin
            s_nxt.rx_word[c] = {1'h0, dres[10:2]};
          end
        end
      end
    end
    // Receive bus driven on both edges of the receive clock
    if (strobe) begin
      s_nxt.rx_clk = !s_r.rx_clk;
      for (int p = 0; p < 4; p++) begin
        if (mux_mode) begin
          s_nxt.rx_lane[p*10 +: 10] = s_nxt.rx_clk ? s_r.rx_word[2*p+1]
                                                   : s_r.rx_word[2*p];
        end else if (nib_mode) begin
          s_nxt.rx_lane[p*10 +: 10] = s_nxt.rx_clk
            ? {s_r.rx_word[2*p+1][4:0], s_r.rx_word[2*p][4:0]}
            : {s_r.rx_word[2*p+1][9:5], s_r.rx_word[2*p][9:5]};
        end else begin
          s_nxt.rx_lane[p*10 +: 10] = '0; // Reserved mode: quiet bus
        end
      end
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_r <= OSX_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs taken straight from state flops
  always_comb begin
    s_axi_awready_o = s_r.awrdy;
    s_axi_wready_o = s_r.wrdy;
    s_axi_bvalid_o = s_r.bvalid;
    s_axi_bresp_o = s_r.bresp;
    s_axi_arready_o = s_r.arrdy;
    s_axi_rvalid_o = s_r.rvalid;
    s_axi_rdata_o = s_r.rdata;
    s_axi_rresp_o = s_r.rresp;
    receive_clock_o = s_r.rx_clk;
    receive_bus_lane_o = s_r.rx_lane;
    rate_compensation_o = s_r.rate_comp;
    for (int c = 0; c < OSX_NCH; c++) begin
      serial_data_o[c] = s_r.shift[c][0];
    end
  end

endmodule : osx_port

/* File: verif/osx_port_sva.sv */
// Checker of bus handshakes and receive clock pacing
`timescale 1ns/1ps
module osx_port_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register bus
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Receive side
  input wire logic receive_clock_o,
  input wire logic [39:0] receive_bus_lane_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Cycles since last toggle; the first toggle only arms the check
  logic rck_q_r;
  logic seen_r;
  logic [4:0] gap_r;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rck_q_r <= 1'b0;
      seen_r <= 1'b0;
      gap_r <= 5'h00;
    end else begin
      rck_q_r <= receive_clock_o;
      seen_r <= seen_r | (receive_clock_o ^ rck_q_r);
      gap_r <= (receive_clock_o ^ rck_q_r) ? 5'h00 : gap_r + 5'h01;
    end
  end
  property p_rck_gap;
    seen_r && (receive_clock_o ^ rck_q_r) |-> gap_r == 5'h09;
  endproperty
  a_rck_gap: assert property (p_rck_gap)
    else $error("receive clock toggled early");
  property p_rck_due;
    seen_r && gap_r == 5'h09 |-> receive_clock_o ^ rck_q_r;
  endproperty
  a_rck_due: assert property (p_rck_due)
    else $error("receive clock toggle missing");
  property p_lane_clk;
    $changed(receive_bus_lane_o) |-> $changed(receive_clock_o);
  endproperty
  a_lane_clk: assert property (p_lane_clk)
    else $error("receive lane moved off its clock");
  property p_b_due;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |=> s_axi_bvalid_o;
  endproperty
  a_b_due: assert property (p_b_due)
    else $error("write response late");
  property p_b_drop;
    $fell(s_axi_bvalid_o) |-> $past(s_axi_bready_i);
  endproperty
  a_b_drop: assert property (p_b_drop)
    else $error("write response dropped unaccepted");
  property p_r_due;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_r_due: assert property (p_r_due)
    else $error("read data late");
  property p_r_drop;
    $fell(s_axi_rvalid_o) |-> $past(s_axi_rready_i);
  endproperty
  a_r_drop: assert property (p_r_drop)
    else $error("read data dropped unaccepted");
  property p_w_block;
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
  endproperty
  a_w_block: assert property (p_w_block)
    else $error("write taken while response pending");
  property p_ar_block;
    s_axi_rvalid_o |-> !s_axi_arready_o;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read taken while data pending");
endmodule : osx_port_sva

/* File: verif/osx_host.sv */
// Host model: DDR pair clocks and transmit lane words
`timescale 1ns/1ps
module osx_host (
  // Controls from the bench
  input wire logic [3:0] run_i,
  input wire logic sync_i,
  input wire logic nib_i,
  input wire logic [9:0] odd_i,
  input wire logic [9:0] even_i,
  // Toward the device
  output logic [3:0] tclk_o,
  output logic [39:0] lane_o
);
  // Lane value of each pair
  logic [9:0] ln [4];
  // Synchronous mode: pair AB timing on all lanes
  assign lane_o = sync_i ? {4{ln[0]}} : {ln[3], ln[2], ln[1], ln[0]};
  for (genvar p = 0; p < 4; p++) begin : g_pair
    // 160 ns clock, data launched 40 ns before each edge, own phase
    initial begin
      tclk_o[p] = 1'b0;
      ln[p] = 10'h155;
      #(37 * p);
      forever begin
        if (!run_i[p]) begin
          // Idle: clock still, stale data replaced by a toggling pattern
          tclk_o[p] = 1'b0;
          ln[p] = ~ln[p];
          #8;
        end else begin
          ln[p] = nib_i ? {odd_i[4:0], even_i[4:0]} : odd_i;
          #40;
          tclk_o[p] = 1'b1;
          #40;
          ln[p] = nib_i ? {odd_i[9:5], even_i[9:5]} : even_i;
          #40;
          tclk_o[p] = 1'b0;
          #40;
        end
      end
    end
  end
endmodule : osx_host

/* File: verif/osx_port_bench.sv */
// Self-checking bench of the serdes mode and transmit port
`timescale 1ns/1ps
module osx_port_bench import osx_pkg::*;;
  // Stimulus, all defined at time zero
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, rx_v = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [79:0] rxs = 80'h0;
  logic [3:0] pins = 4'h0, run = 4'h0;
  logic sync = 1'b1, nib = 1'b0;
  logic [9:0] odd = 10'h000, evn = 10'h000;
  // Responses
  logic awr, wr, bv, arr, rv, rclk, rate;
  logic [1:0] br, rrsp;
  logic [31:0] rdat;
  logic [7:0] ser_o;
  logic [39:0] rlane, lane_tx;
  logic [3:0] tclk;
  int mismatches = 0;
  int cmp_count = 0;
  // Rows: pins{code,a,b,tclk}, control, rx symbol, status, rx lane (3FF: none)
  // Control values keep rate compensation set
  // Rows 4 and 5 send the negative comma while running disparity is positive
  localparam logic [36:0] ROWS [13] = '{
    {4'h0, 8'h40, 10'h2C1, 5'h02, 10'h2C1}, {4'h0, 8'h41, 10'h17C, 5'h03, 10'h1BC},
    {4'h0, 8'h43, 10'h000, 5'h03, 10'h1FF}, {4'h8, 8'h40, 10'h000, 5'h03, 10'h0FF},
    {4'h0, 8'h43, 10'h17C, 5'h03, 10'h1FF}, {4'h0, 8'h41, 10'h17C, 5'h03, 10'h1BC},
    {4'h4, 8'h40, 10'h3FF, 5'h04, 10'h3FF}, {4'h2, 8'h40, 10'h3FF, 5'h10, 10'h3FF},
    {4'h6, 8'h40, 10'h3FF, 5'h10, 10'h3FF}, {4'h4, 8'h44, 10'h3FF, 5'h02, 10'h3FF},
    {4'h0, 8'h4C, 10'h3FF, 5'h04, 10'h3FF}, {4'h1, 8'h40, 10'h3FF, 5'h0A, 10'h3FF},
    {4'h0, 8'h60, 10'h3FF, 5'h0A, 10'h3FF}};
  always #4 clk_i = ~clk_i;
  osx_port i_osx_port (
    .clk_i(clk_i), .reset_n_i(reset_n_i),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_bresp_o(br),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rrsp),
    .coding_select_pin_i(pins[3]), .interface_select_pin_a_i(pins[2]),
    .interface_select_pin_b_i(pins[1]), .transmit_clock_select_pin_i(pins[0]),
    .tx_clock_pair_ab_i(tclk[0]), .tx_clock_pair_cd_i(tclk[1]),
    .tx_clock_pair_ef_i(tclk[2]), .tx_clock_pair_gh_i(tclk[3]),
    .transmit_bus_lane_i(lane_tx), .rx_symbol_valid_i(rx_v), .rx_symbol_i(rxs),
    .serial_data_o(ser_o), .receive_clock_o(rclk), .receive_bus_lane_o(rlane),
    .rate_compensation_o(rate));
  osx_host i_osx_host (.run_i(run), .sync_i(sync), .nib_i(nib), .odd_i(odd),
    .even_i(evn), .tclk_o(tclk), .lane_o(lane_tx));
  // Counts, verdict, end of run
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // A used-up wait bound ends the run
  task automatic late(input logic ok);
    if (!ok) begin
      mismatches++;
      $display("wait bound used up");
      conclude();
    end
  endtask : late
  // Write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_i);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    late(n < 40);
    r = br;
    bry <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_i);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    late(n < 40);
    d = rdat;
    r = rrsp;
    rry <= 1'b0;
  endtask : axi_rd
  // Serial capture; the symbol phase is free, so any rotation may match
  task automatic ser(input int c, input logic [19:0] pat, input string nm);
    logic [39:0] s;
    logic hit;
    hit = 1'b0;
    repeat (48) @(posedge clk_i);
    for (int k = 0; k < 40; k++) begin
      @(posedge clk_i);
      s[k] = ser_o[c];
    end
    for (int k = 0; k < 20; k++) hit |= (s[k +: 20] === pat);
    chk(nm, hit, 1'b1);
    $display("test %s done", nm);
  endtask : ser
  initial begin
    logic [31:0] rd;
    logic [1:0] rs;
    logic [3:0] pv;
    logic [7:0] cv;
    logic [9:0] sv;
    logic [9:0] xv;
    logic [4:0] st;
    int n;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // Table rows: mode status and receive word of channel B
    for (int i = 0; i < 13; i++) begin
      {pv, cv, sv, st, xv} = ROWS[i];
      pins <= pv;
      axi_wr(OSX_CTRL_OFS, {24'h0, cv}, rs);
      repeat (4) @(posedge clk_i);
      axi_rd(OSX_STAT_OFS, rd, rs);
      chk("status", rd[4:0], st);
      if (xv !== 10'h3FF) begin
        rxs <= {60'h0, sv, 10'h0};
        rx_v <= 1'b1;
        @(posedge clk_i);
        rx_v <= 1'b0;
        repeat (22) @(posedge clk_i);
        for (n = 0; n < 12; n++) begin
          @(posedge clk_i);
          if (rclk) break;
        end
        late(n < 12);
        chk("rx lane", rlane[9:0], xv);
      end
      $display("row %0d done", i);
    end
    // Raw multiplexed, all pairs on the AB clock
    pins <= 4'h0;
    axi_wr(OSX_CTRL_OFS, 32'h40, rs);
    odd <= 10'h2C1;
    evn <= 10'h0B3;
    run <= 4'h1;
    ser(1, {2{10'h2C1}}, "ch B raw");
    ser(2, {2{10'h0B3}}, "ch C sync");
    // Soft reset of A spoils partner B only
    axi_wr(OSX_SRST_OFS, 32'h01, rs);
    ser(1, 20'h0, "ch B soft reset");
    ser(3, {2{10'h2C1}}, "ch D kept");
    axi_wr(OSX_SRST_OFS, 32'h0, rs);
    // Independent: AB clock still, others run
    axi_wr(OSX_CTRL_OFS, 32'h60, rs);
    sync <= 1'b0;
    run <= 4'hE;
    // Fresh words, so a stale capture from the AB clock cannot pass
    odd <= 10'h3A5;
    evn <= 10'h05A;
    ser(7, {2{10'h3A5}}, "ch H indep");
    ser(6, {2{10'h05A}}, "ch G indep");
    // Nibble halves
    pins <= 4'h4;
    axi_wr(OSX_CTRL_OFS, 32'h40, rs);
    sync <= 1'b1;
    nib <= 1'b1;
    run <= 4'h1;
    ser(0, {2{10'h05A}}, "ch A nibble");
    ser(1, {2{10'h3A5}}, "ch B nibble");
    // Encoded K28.5 with K bit: both disparity forms alternate
    pins <= 4'h0;
    axi_wr(OSX_CTRL_OFS, 32'h41, rs);
    nib <= 1'b0;
    odd <= 10'h1BC;
    ser(1, 20'hA0D7C, "ch B comma");
    // Bus errors and read-only status; clearing the control bit turns rate compensation off
    pins <= 4'h4;
    axi_rd(8'h0C, rd, rs);
    chk("unmapped rresp", rs, OSX_SLVERR);
    chk("unmapped rdata", rd, 32'h0);
    axi_wr(8'h20, 32'hFF, rs);
    chk("unmapped bresp", rs, OSX_SLVERR);
    axi_wr(OSX_STAT_OFS, 32'hFF, rs);
    chk("status write bresp", rs, OSX_OKAY);
    axi_wr(OSX_CTRL_OFS, 32'h00, rs);
    chk("rate comp off", rate, 1'b0);
    // Second reset in mid-run
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("rate comp in reset", rate, 1'b1);
    reset_n_i <= 1'b1;
    axi_rd(OSX_CTRL_OFS, rd, rs);
    chk("ctrl after reset", rd, 32'h40);
    $display("bus and reset tests done");
    conclude();
  end
endmodule : osx_port_bench
bind osx_port osx_port_sva i_osx_port_sva (.clk_i, .reset_n_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .receive_clock_o, .receive_bus_lane_o);
